// file: dcm_pkg.sv
// constants, field layouts and carrier types of the ADC DC measurement block
// Summary of operation
// - measure the mono ADC channel only while the enable bit is one
// - filter type zero: first-order sinc averaging over two to the power D
// - filter type one: first-order low-pass IIR with coefficient set by D
// - D codes 1..20 map directly; code 0 and 21..31 must not be used
// - update-disable bit set freezes the result registers for clean reads
// - IIR output select: zero instantaneous, one value held before each clearing
// - averaging time code 0 infinite, 1..20 two to that code clock periods
// - result bytes: 23:16 in high, 15:8 in mid, 7:0 in low register
// - all three result bytes read zero after reset until updated
package dcm_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DCM_DATA_W   = 24;
	localparam int DCM_MAXSHIFT = 20;
	localparam int DCM_ADDR_W   = 7;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [6:0] DCM_ADDR_PAGE    = 7'h00;
	localparam logic [6:0] DCM_ADDR_CFG_A   = 7'h66;
	localparam logic [6:0] DCM_ADDR_CFG_B   = 7'h67;
	localparam logic [6:0] DCM_ADDR_RES_HI  = 7'h68;
	localparam logic [6:0] DCM_ADDR_RES_MID = 7'h69;
	localparam logic [6:0] DCM_ADDR_RES_LO  = 7'h6A;
	localparam logic [7:0] DCM_PAGE_MEAS    = 8'h00;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int DCM_A_EN_BIT   = 7;
	localparam int DCM_A_IIR_BIT  = 5;
	localparam int DCM_B_FRZ_BIT  = 6;
	localparam int DCM_B_HOLD_BIT = 5;
	localparam int DCM_FIELD_LSB  = 0;
	localparam int DCM_FIELD_W    = 5;
	localparam logic [7:0] DCM_CFG_A_MASK = 8'hBF;
	localparam logic [7:0] DCM_CFG_B_MASK = 8'h7F;
	localparam logic [7:0] DCM_CFG_RST    = 8'h00;
	localparam logic [7:0] DCM_PAGE_RST   = 8'h00;
	localparam logic [7:0] DCM_RD_NONE    = 8'h00;
	localparam logic [23:0] DCM_RES_RST   = 24'h000000;
	localparam logic [4:0] DCM_CODE_MIN   = 5'h01;
	localparam logic [4:0] DCM_CODE_MAX   = 5'h14;
	localparam logic [4:0] DCM_AVG_INF    = 5'h00;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       enable;
		logic       filtIir;
		logic [4:0] shiftD;
		logic       freeze;
		logic       holdSel;
		logic [4:0] avgT;
	} dcm_cfg_s;

	typedef struct packed {
		logic        valid;
		logic [23:0] data;
	} dcm_sample_s;

	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [6:0] addr;
		logic [7:0] wrData;
	} dcm_reg_req_s;

endpackage

// file: dcm_sinc_avg.sv
// first-order sinc (block average) over two to the power D samples
`timescale 1ns/100ps
module dcm_sinc_avg #(
	parameter int DATA_W   = 24,
	parameter int MAXSHIFT = 20
) (
	input  wire logic                 clk_sys,   // system clock
	input  wire logic                 rst,       // synchronous reset
	input  wire logic                 clear,     // restart the block
	input  wire logic [4:0]           shiftD,    // log2 of block length
	input  wire dcm_pkg::dcm_sample_s sample,    // modulator data
	output logic                      outValid,  // one-cycle result pulse
	output logic [DATA_W-1:0]         outData    // block mean
);
	import dcm_pkg::*;

	localparam int ACC_W = DATA_W + MAXSHIFT;

	logic signed [ACC_W-1:0] acc_q;
	logic        [MAXSHIFT:0] cnt_q;
	logic signed [ACC_W-1:0] accNext;
	logic signed [ACC_W-1:0] quot;
	logic        [MAXSHIFT:0] lastCount;
	logic                     isLast;

	assign lastCount = ({{MAXSHIFT{1'b0}}, 1'b1} << shiftD) - {{MAXSHIFT{1'b0}}, 1'b1};
	assign isLast    = cnt_q == lastCount;
	assign accNext   = acc_q + {{MAXSHIFT{sample.data[DATA_W-1]}}, sample.data};
	assign quot      = accNext >>> shiftD;

	always_ff @(posedge clk_sys) begin
		outValid <= 1'b0;
		if (rst || clear) begin
			acc_q   <= '0;
			cnt_q   <= '0;
			outData <= '0;
		end else if (sample.valid) begin
			if (isLast) begin
				outData  <= quot[DATA_W-1:0];
				outValid <= 1'b1;
				acc_q    <= '0;
				cnt_q    <= '0;
			end else begin
				acc_q <= accNext;
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule // dcm_sinc_avg

// file: dcm_iir_lp.sv
// first-order low-pass IIR, y += (x - y) / 2^D, with fraction bits kept
`timescale 1ns/100ps
module dcm_iir_lp #(
	parameter int DATA_W   = 24,
	parameter int MAXSHIFT = 20
) (
	input  wire logic                 clk_sys,  // system clock
	input  wire logic                 rst,      // synchronous reset
	input  wire logic                 clear,    // zero the state
	input  wire logic [4:0]           shiftD,   // coefficient exponent
	input  wire dcm_pkg::dcm_sample_s sample,   // modulator data
	output logic [DATA_W-1:0]         outData   // filter state, integer part
);
	import dcm_pkg::*;

	localparam int ACC_W = DATA_W + MAXSHIFT;

	logic signed [ACC_W-1:0] acc_q;
	logic signed [ACC_W:0]   diff;
	logic signed [ACC_W:0]   step;
	logic signed [ACC_W-1:0] xExt;

	// fraction bits keep small steps from vanishing at large D
	assign xExt    = {sample.data, {MAXSHIFT{1'b0}}};
	assign diff    = {xExt[ACC_W-1], xExt} - {acc_q[ACC_W-1], acc_q};
	assign step    = diff >>> shiftD;
	assign outData = acc_q[ACC_W-1:MAXSHIFT];

	always_ff @(posedge clk_sys) begin
		if (rst || clear) begin
			acc_q <= '0;
		end else if (sample.valid) begin
			acc_q <= acc_q + step[ACC_W-1:0];
		end
	end
endmodule // dcm_iir_lp

// file: dcm_adc_dc_meas.sv
// DC level measurement of the mono ADC channel with its page-0 registers
`timescale 1ns/100ps
module dcm_adc_dc_meas #(
	parameter int DATA_W   = dcm_pkg::DCM_DATA_W,
	parameter int MAXSHIFT = dcm_pkg::DCM_MAXSHIFT
) (
	input  wire logic                  clk_sys,       // modulator clock
	input  wire logic                  rst,           // synchronous reset, high
	input  wire dcm_pkg::dcm_reg_req_s regReq,        // register access request
	input  wire dcm_pkg::dcm_sample_s  sample,        // ADC modulator/decimation data
	output logic [7:0]                 regRdData_q,   // read data, next cycle
	output logic                       resultValid_q, // pulse on result refresh
	output logic [DATA_W-1:0]          dcLevel_q      // current stored result
);
	import dcm_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (DATA_W != DCM_DATA_W) begin : g_bad_width
		$error("result width must match the three result bytes");
	end
	if (MAXSHIFT < int'(DCM_CODE_MAX)) begin : g_bad_shift
		$error("shift range cannot serve the largest code");
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	function automatic logic regHit(input logic [6:0] addr, input logic [6:0] target,
		input logic [7:0] page);
		regHit = (addr == target) && (page == DCM_PAGE_MEAS);
	endfunction

	logic [7:0] page_q;
	logic [7:0] cfgA_q;
	logic [7:0] cfgB_q;
	logic [7:0] rdSel;
	logic       wrPage;
	logic       wrCfgA;
	logic       wrCfgB;
	dcm_cfg_s   cfg;

	assign wrPage = regReq.wrEn && (regReq.addr == DCM_ADDR_PAGE);
	assign wrCfgA = regReq.wrEn && regHit(regReq.addr, DCM_ADDR_CFG_A, page_q);
	assign wrCfgB = regReq.wrEn && regHit(regReq.addr, DCM_ADDR_CFG_B, page_q);

	assign cfg.enable  = cfgA_q[DCM_A_EN_BIT];
	assign cfg.filtIir = cfgA_q[DCM_A_IIR_BIT];
	assign cfg.shiftD  = cfgA_q[DCM_FIELD_LSB +: DCM_FIELD_W];
	assign cfg.freeze  = cfgB_q[DCM_B_FRZ_BIT];
	assign cfg.holdSel = cfgB_q[DCM_B_HOLD_BIT];
	assign cfg.avgT    = cfgB_q[DCM_FIELD_LSB +: DCM_FIELD_W];

	// reserved bits are not stored and read back as zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			page_q <= DCM_PAGE_RST;
			cfgA_q <= DCM_CFG_RST;
			cfgB_q <= DCM_CFG_RST;
		end else begin
			if (wrPage) begin
				page_q <= regReq.wrData;
			end
			if (wrCfgA) begin
				cfgA_q <= regReq.wrData & DCM_CFG_A_MASK;
			end
			if (wrCfgB) begin
				cfgB_q <= regReq.wrData & DCM_CFG_B_MASK;
			end
		end
	end

	// unmapped and reserved addresses read zero and ignore writes
	assign rdSel =
		(regReq.addr == DCM_ADDR_PAGE)                   ? page_q :
		regHit(regReq.addr, DCM_ADDR_CFG_A,   page_q)    ? cfgA_q :
		regHit(regReq.addr, DCM_ADDR_CFG_B,   page_q)    ? cfgB_q :
		regHit(regReq.addr, DCM_ADDR_RES_HI,  page_q)    ? dcLevel_q[23:16] :
		regHit(regReq.addr, DCM_ADDR_RES_MID, page_q)    ? dcLevel_q[15:8] :
		regHit(regReq.addr, DCM_ADDR_RES_LO,  page_q)    ? dcLevel_q[7:0] :
		DCM_RD_NONE;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			regRdData_q <= DCM_RD_NONE;
		end else if (regReq.rdEn) begin
			regRdData_q <= rdSel;
		end
	end

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	logic paramOk;
	logic avgOk;
	logic runSinc;
	logic runIir;
	logic runAny;

	// a reserved D code stops the measurement rather than guess a coefficient
	assign paramOk = (cfg.shiftD >= DCM_CODE_MIN) && (cfg.shiftD <= DCM_CODE_MAX);
	assign avgOk   = (cfg.avgT != DCM_AVG_INF) && (cfg.avgT <= DCM_CODE_MAX);
	assign runSinc = cfg.enable && !cfg.filtIir && paramOk;
	assign runIir  = cfg.enable && cfg.filtIir && paramOk;
	assign runAny  = runSinc || runIir;

	// ----------------------------------------------------------------
	// filters
	// ----------------------------------------------------------------
	logic              sincValid;
	logic [DATA_W-1:0] sincData;
	logic [DATA_W-1:0] iirOut;
	logic              sincClear;
	logic              iirClear;

	// a new D restarts the filters so no block mixes two settings
	assign sincClear = !runSinc || wrCfgA;

	dcm_sinc_avg #(
		.DATA_W   (DATA_W),
		.MAXSHIFT (MAXSHIFT)
	) u_sinc (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.clear    (sincClear),
		.shiftD   (cfg.shiftD),
		.sample   (sample),
		.outValid (sincValid),
		.outData  (sincData)
	);

	dcm_iir_lp #(
		.DATA_W   (DATA_W),
		.MAXSHIFT (MAXSHIFT)
	) u_iir (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clear   (iirClear),
		.shiftD  (cfg.shiftD),
		.sample  (sample),
		.outData (iirOut)
	);

	// ----------------------------------------------------------------
	// periodic clearing timer
	// ----------------------------------------------------------------
	logic [MAXSHIFT:0] avgCnt_q;
	logic [MAXSHIFT:0] avgLast;
	logic              periodLast;

	assign avgLast    = ({{MAXSHIFT{1'b0}}, 1'b1} << cfg.avgT) - {{MAXSHIFT{1'b0}}, 1'b1};
	assign periodLast = runIir && avgOk && (avgCnt_q == avgLast);
	assign iirClear   = !runIir || wrCfgA || periodLast;

	always_ff @(posedge clk_sys) begin
		if (rst || !runIir || !avgOk || periodLast || wrCfgB) begin
			avgCnt_q <= '0;
		end else begin
			avgCnt_q <= avgCnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// result selection and update
	// ----------------------------------------------------------------
	logic              candValid;
	logic [DATA_W-1:0] candData;
	logic              iirInst;

	// held mode without a period has no clearing, so it reports the live value
	assign iirInst   = runIir && (!cfg.holdSel || !avgOk);
	assign candValid = (runSinc && sincValid) || iirInst || (runIir && cfg.holdSel && periodLast);
	assign candData  = runSinc ? sincData : iirOut;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dcLevel_q     <= DCM_RES_RST;
			resultValid_q <= 1'b0;
		end else begin
			resultValid_q <= candValid && !cfg.freeze;
			if (candValid && !cfg.freeze) begin
				dcLevel_q <= candData;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_disabled_quiet;
		@(posedge clk_sys) disable iff (rst)
		!runAny |=> !resultValid_q;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("update while disabled");

	property p_sinc_result;
		@(posedge clk_sys) disable iff (rst)
		(runSinc && sincValid && !cfg.freeze) |=> (dcLevel_q == $past(sincData)) && resultValid_q;
	endproperty
	a_sinc_result: assert property (p_sinc_result) else $error("sinc result not stored");

	property p_iir_live;
		@(posedge clk_sys) disable iff (rst)
		(runIir && !cfg.holdSel && !cfg.freeze) |=> dcLevel_q == $past(iirOut);
	endproperty
	a_iir_live: assert property (p_iir_live) else $error("instantaneous IIR value lost");

	property p_reserved_d;
		@(posedge clk_sys) disable iff (rst)
		!paramOk |=> !resultValid_q;
	endproperty
	a_reserved_d: assert property (p_reserved_d) else $error("reserved D code measured");

	property p_freeze;
		@(posedge clk_sys) disable iff (rst)
		cfg.freeze |=> $stable(dcLevel_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("result changed while frozen");

	property p_hold_between;
		@(posedge clk_sys) disable iff (rst)
		(runIir && cfg.holdSel && avgOk && !periodLast) |=> $stable(dcLevel_q);
	endproperty
	a_hold_between: assert property (p_hold_between) else $error("held value moved mid-period");

	property p_period_two;
		@(posedge clk_sys) disable iff (rst)
		(periodLast && cfg.avgT == DCM_CODE_MIN) ##1 (runIir && !wrCfgA && !wrCfgB && cfg.avgT == DCM_CODE_MIN) |=> periodLast;
	endproperty
	a_period_two: assert property (p_period_two) else $error("period of two cycles broken");

	property p_byte_high;
		@(posedge clk_sys) disable iff (rst)
		(regReq.rdEn && regHit(regReq.addr, DCM_ADDR_RES_HI, page_q)) |=> regRdData_q == $past(dcLevel_q[23:16]);
	endproperty
	a_byte_high: assert property (p_byte_high) else $error("high result byte misplaced");

	property p_reset_zero;
		@(posedge clk_sys) disable iff (rst)
		$fell(rst) |-> (dcLevel_q == DCM_RES_RST) && (cfgA_q == DCM_CFG_RST);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("result not zero after reset");

endmodule // dcm_adc_dc_meas

// file: dcm_sample_src.sv
// behavioural model of the mono ADC modulator data path feeding the block
`timescale 1ns/100ps
module dcm_sample_src (
	input  wire logic                 clk_sys, // modulator clock
	input  wire logic                 rst,     // synchronous reset
	input  wire logic [23:0]          valA,    // value on even samples
	input  wire logic [23:0]          valB,    // value on odd samples
	input  wire logic                 slow,    // one sample every third cycle
	output dcm_pkg::dcm_sample_s      sample   // sample stream to the block
);
	import dcm_pkg::*;

	// ----------------------------------------------------------------
	// sample pacing
	// ----------------------------------------------------------------
	logic [1:0] gapCnt;
	logic       phase;

	initial begin
		sample = '0;
		gapCnt = 2'h0;
		phase  = 1'b0;
	end

	// data toggles between samples so a stale value is never mistaken for a new one
	always @(posedge clk_sys) begin
		#1;
		if (rst) begin
			sample = '0;
			gapCnt = 2'h0;
			phase  = 1'b0;
		end else begin
			gapCnt = (gapCnt == 2'h2) ? 2'h0 : gapCnt + 2'h1;
			sample.valid = !slow || (gapCnt == 2'h0);
			if (sample.valid) begin
				sample.data = phase ? valB : valA;
				phase       = !phase;
			end else begin
				sample.data = ~sample.data;
			end
		end
	end
endmodule // dcm_sample_src

// file: dcm_adc_dc_meas_test.sv
// self-checking testbench of the ADC DC measurement block
`timescale 1ns/100ps
module dcm_adc_dc_meas_test;
	import dcm_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic         clk_sys;
	logic         rst;
	dcm_reg_req_s regReq;
	dcm_sample_s  sample;
	logic [7:0]   regRdData_q;
	logic         resultValid_q;
	logic [23:0]  dcLevel_q;
	logic [23:0]  valA;
	logic [23:0]  valB;
	logic         slow;
	logic [23:0]  keep;
	int           errTotal;
	int           compares;
	int           cycles;

	dcm_adc_dc_meas i_dcm_adc_dc_meas (.clk_sys(clk_sys), .rst(rst), .regReq(regReq),
		.sample(sample), .regRdData_q(regRdData_q), .resultValid_q(resultValid_q),
		.dcLevel_q(dcLevel_q));
	dcm_sample_src i_dcm_sample_src (.clk_sys(clk_sys), .rst(rst), .valA(valA), .valB(valB),
		.slow(slow), .sample(sample));

	// ----------------------------------------------------------------
	// clock, watchdog, verdict
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic tallyAndFinish();
		if (errTotal == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// the whole sequence needs about six hundred cycles; this ceiling leaves ample margin
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			errTotal = errTotal + 1;
			tallyAndFinish();
		end
	end

	// ----------------------------------------------------------------
	// compares and bus tasks
	// ----------------------------------------------------------------
	task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			errTotal = errTotal + 1;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkLevel(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			errTotal = errTotal + 1;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkCount(input string what, input int exp, input int got);
		compares = compares + 1;
		if (got != exp) begin
			errTotal = errTotal + 1;
			$display("unexpected %s: expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		@(posedge clk_sys) #1;
		regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: addr, wrData: data};
		@(posedge clk_sys) #1;
		regReq.wrEn = 1'b0;
	endtask

	task automatic rdChk(input string what, input logic [6:0] addr, input logic [7:0] exp);
		@(posedge clk_sys) #1;
		regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: addr, wrData: 8'h00};
		@(posedge clk_sys) #1;
		regReq.rdEn = 1'b0;
		chkByte(what, exp, regRdData_q);
	endtask

	// counts result pulses over a fixed span; bounded, so a dead path cannot hang
	task automatic pulses(input int span, output int n);
		n = 0;
		repeat (span) begin
			@(posedge clk_sys) #1;
			if (resultValid_q === 1'b1) n = n + 1;
		end
	endtask

	task automatic waitPulses(input int want);
		int n;
		int t;
		n = 0;
		t = 0;
		while (n < want && t < 400) begin
			@(posedge clk_sys) #1;
			if (resultValid_q === 1'b1) n = n + 1;
			t = t + 1;
		end
		chkCount("result pulses seen", want, n);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		errTotal = 0;
		compares = 0;
		cycles   = 0;
		regReq   = '0;
		valA     = 24'h000010;
		valB     = 24'h000020;
		slow     = 1'b0;
		rst      = 1'b1;
		repeat (10) @(posedge clk_sys);
		#1 rst = 1'b0;
		// reset values and read-only result bytes
		rdChk("cfg a reset", DCM_ADDR_CFG_A, 8'h00);
		rdChk("cfg b reset", DCM_ADDR_CFG_B, 8'h00);
		wr(DCM_ADDR_RES_HI, 8'h5A);
		rdChk("res hi reset", DCM_ADDR_RES_HI, 8'h00);
		rdChk("res mid reset", DCM_ADDR_RES_MID, 8'h00);
		rdChk("res lo reset", DCM_ADDR_RES_LO, 8'h00);
		rdChk("reserved range", 7'h5E, 8'h00);
		// reserved configuration bits are only ever written as zero
		wr(DCM_ADDR_CFG_A, 8'h01);
		rdChk("cfg a reserved bit", DCM_ADDR_CFG_A, 8'h01);
		wr(DCM_ADDR_CFG_B, 8'h14);
		rdChk("cfg b reserved bit", DCM_ADDR_CFG_B, 8'h14);
		// page other than zero hides the measurement registers
		wr(DCM_ADDR_PAGE, 8'h01);
		wr(DCM_ADDR_CFG_A, 8'h85);
		rdChk("cfg a off page", DCM_ADDR_CFG_A, 8'h00);
		wr(DCM_ADDR_PAGE, DCM_PAGE_MEAS);
		rdChk("cfg a back on page", DCM_ADDR_CFG_A, 8'h01);
		// disabled: no refresh
		pulses(40, n);
		chkCount("pulses while disabled", 0, n);
		// sinc, D=1, pairs of 0x10 and 0x20 average to 0x18
		wr(DCM_ADDR_CFG_A, 8'h81);
		waitPulses(3);
		chkLevel("sinc mean", 24'h000018, dcLevel_q);
		// negative pair rounds towards minus infinity, partner paced slowly
		valA = 24'hFFFFFD;
		valB = 24'h000000;
		slow = 1'b1;
		waitPulses(3);
		chkLevel("sinc negative mean", 24'hFFFFFE, dcLevel_q);
		// freeze first, new input only after it, so no mixed block lands
		wr(DCM_ADDR_CFG_B, 8'h40);
		valA = 24'h123456;
		valB = 24'h123456;
		pulses(60, n);
		chkCount("pulses while frozen", 0, n);
		chkLevel("frozen level", 24'hFFFFFE, dcLevel_q);
		rdChk("res hi", DCM_ADDR_RES_HI, 8'hFF);
		rdChk("res mid", DCM_ADDR_RES_MID, 8'hFF);
		rdChk("res lo", DCM_ADDR_RES_LO, 8'hFE);
		wr(DCM_ADDR_CFG_B, 8'h00);
		waitPulses(3);
		chkLevel("level after unfreeze", 24'h123456, dcLevel_q);
		rdChk("res hi new", DCM_ADDR_RES_HI, 8'h12);
		rdChk("res lo new", DCM_ADDR_RES_LO, 8'h56);
		// reserved D codes and disable keep the last result
		wr(DCM_ADDR_CFG_A, 8'h80);
		keep = dcLevel_q;
		valA = 24'h000100;
		valB = 24'h000100;
		slow = 1'b0;
		pulses(40, n);
		chkCount("pulses with D code zero", 0, n);
		wr(DCM_ADDR_CFG_A, 8'h95);
		pulses(40, n);
		chkCount("pulses with D code 21", 0, n);
		wr(DCM_ADDR_CFG_A, 8'h14);
		pulses(40, n);
		chkCount("pulses after disable", 0, n);
		chkLevel("level kept", keep, dcLevel_q);
		// D=4 still runs a 16-sample block, with a constant input the mean is exact
		wr(DCM_ADDR_CFG_A, 8'h84);
		waitPulses(2);
		chkLevel("sinc D=4 mean", 24'h000100, dcLevel_q);
		// iir live: refresh every cycle, level settles at the input
		valA = 24'h040000;
		valB = 24'h040000;
		wr(DCM_ADDR_CFG_A, 8'hA1);
		pulses(80, n);
		chkCount("iir live pulses", 80, n);
		chkByte("iir settled", 8'h01,
			{7'h00, (dcLevel_q <= 24'h040000) && (dcLevel_q >= 24'h03FFFF)});
		// iir held, T=2: one capture every 4 cycles, before the filter settles
		wr(DCM_ADDR_CFG_B, 8'h22);
		pulses(20, n);
		pulses(40, n);
		chkCount("iir held pulses", 10, n);
		chkByte("iir held level", 8'h01,
			{7'h00, (dcLevel_q <= 24'h03C000) && (dcLevel_q >= 24'h01FFFF)});
		// held, T=1: one capture every 2 cycles
		wr(DCM_ADDR_CFG_B, 8'h21);
		pulses(4, n);
		pulses(20, n);
		chkCount("iir held T=1 pulses", 10, n);
		// held with infinite averaging acts as live
		wr(DCM_ADDR_CFG_B, 8'h20);
		pulses(40, n);
		chkCount("iir infinite pulses", 40, n);
		tallyAndFinish();
	end
endmodule // dcm_adc_dc_meas_test
